// file: src/dacr_map.svh
// Register map constants of the converter configuration bank.
// Included by the bank's package user; holds definitions only.
`ifndef DACR_MAP_SVH
`define DACR_MAP_SVH

// ==========================================================
// Register addresses (13-bit address field)
`define DACR_ADR_PORT 13'h0000
`define DACR_ADR_ID 13'h0001
`define DACR_ADR_GRADE 13'h0002
`define DACR_ADR_INDEX 13'h0005
`define DACR_ADR_POWER 13'h0008
`define DACR_ADR_CLOCK 13'h0009
`define DACR_ADR_DIV 13'h000B
`define DACR_ADR_XFER 13'h00FF

// ==========================================================
// Reset values
`define DACR_RST_PORT 8'h18
`define DACR_RST_INDEX 8'h33
`define DACR_RST_POWER 2'h0
`define DACR_RST_DIV 3'h0

// ==========================================================
// Field positions
`define DACR_PORT_LSB_HI 6
`define DACR_PORT_LSB_LO 1
`define DACR_PORT_SR_HI 5
`define DACR_PORT_SR_LO 2
`define DACR_IDX_DCO 5
`define DACR_IDX_FCO 4
`define DACR_IDX_B 1
`define DACR_IDX_A 0
`define DACR_GRADE_LSB 4
`define DACR_INSTR_RD 15
`define DACR_INSTR_WHI 14
`define DACR_INSTR_WLO 13
`define DACR_WLEN_STREAM 2'h3
`define DACR_LAST_INSTR_BIT 4'hF
`define DACR_LAST_DATA_BIT 4'h7

`endif

// file: src/dacr_pkg.sv
// Types shared by the converter configuration bank.
// Assumes the map header is included by users that need offsets.
package dacr_pkg;

	// ==========================================================
	// Serial frame states
	typedef enum logic [2:0]
	{
		DACR_IDLE = 3'b001,
		DACR_INSTR = 3'b010,
		DACR_DATA = 3'b100
	} dacr_state_type;

	// ==========================================================
	// Global power modes
	typedef enum logic [1:0]
	{
		DACR_PWR_RUN = 2'b00,
		DACR_PWR_DOWN = 2'b01,
		DACR_PWR_STBY = 2'b10,
		DACR_PWR_RESET = 2'b11
	} dacr_pwr_type;

endpackage

// file: src/dacr_bank.sv
// Configuration register bank behind a three-wire serial port.
// Assumes serial pins are asynchronous to i_mclk and the serial clock
// runs at most at a quarter of i_mclk.
// Contract
// R1: Port setup reads bits 7,0 as zero and bits 4,3 as one.
// R2: Port is three-wire; every access carries a 16-bit instruction.
// R3: Soft reset bit restores all defaults, then reads back cleared.
// R4: Port byte mirrored; bits 6/1 pick LSB first, 5/2 soft reset.
// R5: Read-only 8-bit part identity code; writes ignored.
// R6: Read-only speed grade field; other bits read zero.
// R7: Write target bits select data clock, frame clock, B, A; default all.
// R8: Setting override commit bit applies pending override, default zero.
// R9: Power field: 00 run, 01 power-down, 10 standby, 11 reset.
// R10: Clock bit 0 enables duty cycle stabilizer; resets off.
// R11: Divide field divides input clock by value plus one.
// R12: Global registers ignore write target selection.
// R13: Local reads with all targets set return channel A.
`timescale 1ns/10ps
`include "dacr_map.svh"

module dacr_bank
	import dacr_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value
	parameter logic [2:0] SPEED_GRADE = 3'h1 // Arbitrary value
)
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Serial port pins
	input wire logic i_sclk,
	input wire logic i_csb,
	input wire logic i_sdio,
	output logic o_sdio,
	output logic o_sdio_oe,
	// Configuration outputs
	output logic o_lsb_first,
	output logic [3:0] o_target_sel,
	output dacr_pwr_type o_power_mode,
	output logic o_dcs_en,
	output logic [2:0] o_clk_div,
	output logic o_override_apply,
	output logic o_soft_reset
);

	// ==========================================================
	// Read mux
	function automatic logic [7:0] rdval(
		input logic [12:0] a,
		input logic lsb,
		input logic [3:0] idx,
		input logic [1:0] pwr,
		input logic dcs,
		input logic [2:0] div,
		input logic xfer
	);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`DACR_ADR_PORT:
			begin
				v = `DACR_RST_PORT; // R1
				v[`DACR_PORT_LSB_HI] = lsb; // R4
				v[`DACR_PORT_LSB_LO] = lsb; // R4
			end
			`DACR_ADR_ID: v = PART_ID; // R5
			`DACR_ADR_GRADE: v[`DACR_GRADE_LSB +: 3] = SPEED_GRADE; // R6
			`DACR_ADR_INDEX:
			begin
				// One shared copy, so a read returns the channel A view
				v[`DACR_IDX_DCO] = idx[3]; // R13
				v[`DACR_IDX_FCO] = idx[2];
				v[`DACR_IDX_B] = idx[1];
				v[`DACR_IDX_A] = idx[0];
			end
			`DACR_ADR_POWER: v[1:0] = pwr;
			`DACR_ADR_CLOCK: v[0] = dcs;
			`DACR_ADR_DIV: v[2:0] = div;
			`DACR_ADR_XFER: v[0] = xfer;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
	logic csb_s1_r, csb_s2_r;
	logic sdio_s1_r, sdio_s2_r;
	logic rise, fall;

	always_ff @(posedge i_mclk)
	begin
		sclk_s1_r <= i_sclk;
		sclk_s2_r <= sclk_s1_r;
		sclk_s3_r <= sclk_s2_r;
		csb_s1_r <= i_csb;
		csb_s2_r <= csb_s1_r;
		sdio_s1_r <= i_sdio;
		sdio_s2_r <= sdio_s1_r;
	end

	assign rise = sclk_s2_r & ~sclk_s3_r;
	assign fall = ~sclk_s2_r & sclk_s3_r;

	// ==========================================================
	// Frame and register state
	localparam logic [7:0] IDX_DEF = `DACR_RST_INDEX;
	dacr_state_type st_r, st_nxt;
	logic [3:0] bcnt_r, bcnt_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic rd_r, rd_nxt;
	logic [1:0] wlen_r, wlen_nxt;
	logic [1:0] bytes_r, bytes_nxt;
	logic done_r, done_nxt;
	logic [12:0] addr_r, addr_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic sdo_r, sdo_nxt;
	logic oe_r, oe_nxt;
	logic lsb_r, lsb_nxt;
	logic [3:0] idx_r, idx_nxt;
	logic [1:0] pwr_r, pwr_nxt;
	logic dcs_r, dcs_nxt;
	logic [2:0] div_r, div_nxt;
	logic xfer_r, xfer_nxt;
	logic apply_r, apply_nxt;
	logic srst_r, srst_nxt;
	logic wr_en;
	logic [7:0] wr_byte;
	logic [12:0] step_addr;

	always_comb
	begin
		st_nxt = st_r;
		bcnt_nxt = bcnt_r;
		sh_nxt = sh_r;
		rd_nxt = rd_r;
		wlen_nxt = wlen_r;
		bytes_nxt = bytes_r;
		done_nxt = done_r;
		addr_nxt = addr_r;
		tx_nxt = tx_r;
		sdo_nxt = sdo_r;
		oe_nxt = oe_r;
		lsb_nxt = lsb_r;
		idx_nxt = idx_r;
		pwr_nxt = pwr_r;
		dcs_nxt = dcs_r;
		div_nxt = div_r;
		xfer_nxt = xfer_r;
		apply_nxt = 1'b0;
		srst_nxt = 1'b0;
		wr_en = 1'b0;
		wr_byte = 8'h00;
		// Address walks down in MSB-first order and up in LSB-first
		step_addr = lsb_r ? addr_r + 13'h0001 : addr_r - 13'h0001;

		// Commit bit is consumed one cycle after it is set
		if (xfer_r)
		begin
			apply_nxt = 1'b1; // R8
			xfer_nxt = 1'b0;
		end

		if (csb_s2_r)
		begin
			st_nxt = DACR_IDLE;
			oe_nxt = 1'b0;
		end
		else
		begin
			unique case (st_r)
				DACR_IDLE:
				begin
					st_nxt = DACR_INSTR;
					bcnt_nxt = 4'h0;
					if (rise)
					begin
						sh_nxt = lsb_r ? {sdio_s2_r, sh_r[15:1]}
							: {sh_r[14:0], sdio_s2_r};
						bcnt_nxt = 4'h1;
					end
				end
				DACR_INSTR:
				begin
					if (rise)
					begin
						sh_nxt = lsb_r ? {sdio_s2_r, sh_r[15:1]}
							: {sh_r[14:0], sdio_s2_r};
						bcnt_nxt = bcnt_r + 4'h1;
						if (bcnt_r == `DACR_LAST_INSTR_BIT) // R2
						begin
							st_nxt = DACR_DATA;
							bcnt_nxt = 4'h0;
							rd_nxt = sh_nxt[`DACR_INSTR_RD];
							wlen_nxt = sh_nxt[`DACR_INSTR_WHI:`DACR_INSTR_WLO];
							addr_nxt = sh_nxt[12:0];
							bytes_nxt = 2'h0;
							done_nxt = 1'b0;
							tx_nxt = rdval(sh_nxt[12:0], lsb_r, idx_r,
								pwr_r, dcs_r, div_r, xfer_r);
						end
					end
				end
				DACR_DATA:
				begin
					if (fall && rd_r && !done_r)
					begin
						sdo_nxt = lsb_r ? tx_r[0] : tx_r[7];
						tx_nxt = lsb_r ? {1'b0, tx_r[7:1]}
							: {tx_r[6:0], 1'b0};
					end
					if (rise)
					begin
						sh_nxt = lsb_r ? {sdio_s2_r, sh_r[15:1]}
							: {sh_r[14:0], sdio_s2_r};
						bcnt_nxt = bcnt_r + 4'h1;
						if (bcnt_r == `DACR_LAST_DATA_BIT)
						begin
							bcnt_nxt = 4'h0;
							wr_byte = lsb_r ? sh_nxt[15:8] : sh_nxt[7:0];
							wr_en = ~rd_r & ~done_r;
							addr_nxt = step_addr;
							bytes_nxt = bytes_r + 2'h1;
							done_nxt = done_r
								| (wlen_r != `DACR_WLEN_STREAM
								&& bytes_r == wlen_r);
							if (rd_r)
								tx_nxt = rdval(step_addr, lsb_r, idx_r,
									pwr_r, dcs_r, div_r, xfer_r);
						end
					end
					// Release the pin in the same edge the count ends
					oe_nxt = rd_r & ~done_nxt;
				end
			endcase
		end

		// Global registers: write target selection does not gate them
		if (wr_en) // R12
		begin
			unique case (addr_r)
				`DACR_ADR_PORT:
				begin
					if (wr_byte[`DACR_PORT_SR_HI] | wr_byte[`DACR_PORT_SR_LO])
						srst_nxt = 1'b1; // R3 R4
					else
						lsb_nxt = wr_byte[`DACR_PORT_LSB_HI]
							| wr_byte[`DACR_PORT_LSB_LO]; // R4
				end
				`DACR_ADR_INDEX:
					idx_nxt = {wr_byte[`DACR_IDX_DCO], wr_byte[`DACR_IDX_FCO],
						wr_byte[`DACR_IDX_B], wr_byte[`DACR_IDX_A]}; // R7
				`DACR_ADR_POWER: pwr_nxt = wr_byte[1:0]; // R9
				`DACR_ADR_CLOCK: dcs_nxt = wr_byte[0]; // R10
				`DACR_ADR_DIV: div_nxt = wr_byte[2:0]; // R11
				`DACR_ADR_XFER: xfer_nxt = wr_byte[0]; // R8
				default: ; // Identity and open locations ignore writes
			endcase
		end

		// Soft reset restores defaults; its bit reads back as zero
		if (srst_r) // R3
		begin
			lsb_nxt = 1'b0;
			idx_nxt = {IDX_DEF[`DACR_IDX_DCO],
				IDX_DEF[`DACR_IDX_FCO],
				IDX_DEF[`DACR_IDX_B],
				IDX_DEF[`DACR_IDX_A]};
			pwr_nxt = `DACR_RST_POWER;
			dcs_nxt = 1'b0;
			div_nxt = `DACR_RST_DIV;
			xfer_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			st_r <= DACR_IDLE;
			bcnt_r <= 4'h0;
			sh_r <= 16'h0000;
			rd_r <= 1'b0;
			wlen_r <= 2'h0;
			bytes_r <= 2'h0;
			done_r <= 1'b0;
			addr_r <= 13'h0000;
			tx_r <= 8'h00;
			sdo_r <= 1'b0;
			oe_r <= 1'b0;
			lsb_r <= 1'b0;
			idx_r <= 4'hF;
			pwr_r <= `DACR_RST_POWER;
			dcs_r <= 1'b0;
			div_r <= `DACR_RST_DIV;
			xfer_r <= 1'b0;
			apply_r <= 1'b0;
			srst_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			bcnt_r <= bcnt_nxt;
			sh_r <= sh_nxt;
			rd_r <= rd_nxt;
			wlen_r <= wlen_nxt;
			bytes_r <= bytes_nxt;
			done_r <= done_nxt;
			addr_r <= addr_nxt;
			tx_r <= tx_nxt;
			sdo_r <= sdo_nxt;
			oe_r <= oe_nxt;
			lsb_r <= lsb_nxt;
			idx_r <= idx_nxt;
			pwr_r <= pwr_nxt;
			dcs_r <= dcs_nxt;
			div_r <= div_nxt;
			xfer_r <= xfer_nxt;
			apply_r <= apply_nxt;
			srst_r <= srst_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_sdio = sdo_r;
	assign o_sdio_oe = oe_r;
	assign o_lsb_first = lsb_r;
	assign o_target_sel = idx_r; // R7
	assign o_power_mode = dacr_pwr_type'(pwr_r); // R9
	assign o_dcs_en = dcs_r; // R10
	assign o_clk_div = div_r; // R11
	assign o_override_apply = apply_r; // R8
	assign o_soft_reset = srst_r; // R3

	// ==========================================================
	// Checks
	logic [7:0] port_rd;
	assign port_rd = rdval(`DACR_ADR_PORT, lsb_r, idx_r, pwr_r, dcs_r,
		div_r, xfer_r);

	sequence s_commit_set;
		xfer_r;
	endsequence
	sequence s_apply_once;
		apply_r ##1 !apply_r;
	endsequence
	sequence s_srst_pulse;
		srst_r ##1 !srst_r;
	endsequence

	port_fixed_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R1
		port_rd[7] == 1'b0 && port_rd[0] == 1'b0 && port_rd[4:3] == 2'b11
		&& port_rd[5] == 1'b0 && port_rd[2] == 1'b0
		&& port_rd[6] == port_rd[1])
		else $error("port setup byte malformed");
	soft_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
		srst_r |=> !lsb_r && idx_r == 4'hF && pwr_r == 2'h0 && !dcs_r
		&& div_r == 3'h0)
		else $error("soft reset left a register off default");
	srst_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
		$rose(srst_r) |-> s_srst_pulse)
		else $error("soft reset bit did not clear");
	id_read_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R5
		rdval(`DACR_ADR_ID, lsb_r, idx_r, pwr_r, dcs_r, div_r, xfer_r)
		== PART_ID)
		else $error("identity code changed");
	commit_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R8
		s_commit_set |=> s_apply_once)
		else $error("override commit not applied once");
	power_wr_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R12
		wr_en && addr_r == `DACR_ADR_POWER && !srst_r
		|=> pwr_r == $past(wr_byte[1:0]))
		else $error("power write lost");
	div_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R11
		$changed(div_r) |-> $past(wr_en) || $past(srst_r))
		else $error("divider changed without a write");
	drive_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R2
		oe_r |-> rd_r && st_r == DACR_DATA && !done_r)
		else $error("data pin driven outside read phase");
	idle_a: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R2
		csb_s2_r |=> st_r == DACR_IDLE && !oe_r)
		else $error("frame not ended by chip select");

endmodule

// file: dv/dacr_host.sv
// Serial host model that drives the three-wire configuration port.
// Assumes i_mclk is the bank clock; pins change on its falling edge.
`timescale 1ns/10ps
module dacr_host
(
	// Clock
	input wire logic i_mclk,
	// Serial pins
	input wire logic i_sdio_wire,
	output logic o_sclk,
	output logic o_csb,
	output logic o_sdio
);
	// ==========================================================
	// Bit timing
	// Six mclk per phase leaves margin for the two-flop pin sync
	localparam int HALF = 6;
	logic lsb_first = 1'b0;

	initial
	begin
		o_sclk = 1'b0;
		o_csb = 1'b1;
		o_sdio = 1'b0;
	end

	task automatic bit_cyc(input logic b, output logic s);
		o_sdio = b;
		repeat (HALF) @(negedge i_mclk);
		o_sclk = 1'b1;
		s = i_sdio_wire;
		repeat (HALF) @(negedge i_mclk);
		o_sclk = 1'b0;
	endtask

	// ==========================================================
	// One frame: instruction, then one byte
	task automatic frame(input logic rd, input logic [12:0] adr,
		input logic [7:0] wd, output logic [7:0] rdat);
		logic [15:0] ins;
		logic s;
		int k;
		ins = {rd, 2'b00, adr};
		o_csb = 1'b0;
		repeat (HALF) @(negedge i_mclk);
		for (k = 0; k < 16; k++)
			bit_cyc(ins[lsb_first ? k : 15 - k], s);
		for (k = 0; k < 8; k++)
		begin
			// Toggle while released so stale levels never pass
			bit_cyc(rd ? ~o_sdio : wd[lsb_first ? k : 7 - k], s);
			rdat[lsb_first ? k : 7 - k] = s;
		end
		repeat (HALF) @(negedge i_mclk);
		o_csb = 1'b1;
		o_sdio = ~o_sdio;
		repeat (8) @(negedge i_mclk);
	endtask
endmodule

// file: dv/test_dual_adc_config_register_bank.sv
// Self-checking bench for the converter configuration bank.
// Assumes the host model in dacr_host and the map header.
`timescale 1ns/10ps
`include "dacr_map.svh"
module test_dual_adc_config_register_bank
	import dacr_pkg::*;
;
	// ==========================================================
	// Signals
	localparam logic [7:0] PART_ID = 8'h3C; // Arbitrary value
	localparam logic [2:0] GRADE = 3'h5; // Arbitrary value
	localparam logic [12:0] ADR [4] = '{`DACR_ADR_INDEX,
		`DACR_ADR_POWER, `DACR_ADR_CLOCK, `DACR_ADR_DIV};
	localparam logic [7:0] MSK [4] = '{8'h33, 8'h03, 8'h01, 8'h07};
	localparam logic [7:0] DEF [4] = '{8'h33, 8'h00, 8'h00, 8'h00};
	logic i_mclk, i_rstn, sclk, csb, sdio_h, sdio_d, sdio_oe, lsb;
	logic [3:0] tsel;
	dacr_pwr_type pwr;
	logic dcs, ovr, srst, exp_lsb;
	logic [2:0] div;
	logic [7:0] sh [4];
	int num_errors = 0;
	int comparisons = 0;
	int n_ovr = 0;
	int n_srst = 0;
	int i, k;
	wire sdio_w = sdio_oe ? sdio_d : sdio_h;

	dacr_host host_u
	(
		.i_mclk(i_mclk),
		.i_sdio_wire(sdio_w),
		.o_sclk(sclk),
		.o_csb(csb),
		.o_sdio(sdio_h)
	);

	dacr_bank #(.PART_ID(PART_ID), .SPEED_GRADE(GRADE)) dut_u
	(
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_sclk(sclk),
		.i_csb(csb),
		.i_sdio(sdio_w),
		.o_sdio(sdio_d),
		.o_sdio_oe(sdio_oe),
		.o_lsb_first(lsb),
		.o_target_sel(tsel),
		.o_power_mode(pwr),
		.o_dcs_en(dcs),
		.o_clk_div(div),
		.o_override_apply(ovr),
		.o_soft_reset(srst)
	);

	initial
	begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	always @(posedge i_mclk)
	begin
		n_ovr <= n_ovr + int'(ovr === 1'b1);
		n_srst <= n_srst + int'(srst === 1'b1);
	end

	// ==========================================================
	// Tasks
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] x;
		host_u.frame(1'b0, a, d, x);
	endtask

	task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
		logic [7:0] x;
		host_u.frame(1'b1, a, 8'h00, x);
		check("readback", x, e);
	endtask

	task automatic wr_sh(input int s, input logic [7:0] d);
		wr(ADR[s], d);
		sh[s] = d & MSK[s];
	endtask

	task automatic chk_out();
		check("target", {4'h0, tsel}, {4'h0, sh[0][5:4], sh[0][1:0]});
		check("power", {6'h0, pwr}, sh[1]);
		check("dcs", {7'h0, dcs}, sh[2]);
		check("div", {5'h0, div}, sh[3]);
		check("lsb", {7'h0, lsb}, {7'h0, exp_lsb});
		for (int s = 0; s < 4; s++)
			rd_chk(ADR[s], sh[s]);
	endtask

	task automatic stop_test();
		$display("Comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial
	begin
		i_rstn = 1'b0;
		exp_lsb = 1'b0;
		sh = DEF;
		void'($urandom(32'hae42));
		repeat (6) @(negedge i_mclk);
		i_rstn = 1'b1;
		repeat (8) @(negedge i_mclk);
		chk_out();
		rd_chk(`DACR_ADR_PORT, 8'h18);
		rd_chk(`DACR_ADR_ID, PART_ID);
		rd_chk(`DACR_ADR_GRADE, {1'b0, GRADE, 4'h0});
		rd_chk(`DACR_ADR_XFER, 8'h00);
		check("oe", {7'h0, sdio_oe}, 8'h00);
		for (i = 0; i < 4; i++)
			wr_sh(1, 8'(i));
		chk_out();
		for (i = 0; i < 16; i++)
		begin
			wr_sh($urandom_range(3), 8'($urandom));
			chk_out();
		end
		wr(`DACR_ADR_ID, ~PART_ID);
		wr(`DACR_ADR_GRADE, 8'hFF);
		wr(13'h0013, 8'hFF);
		rd_chk(`DACR_ADR_ID, PART_ID);
		rd_chk(`DACR_ADR_GRADE, {1'b0, GRADE, 4'h0});
		rd_chk(13'h0013, 8'h00);
		k = n_ovr;
		wr(`DACR_ADR_XFER, 8'h01);
		check("override", 8'(n_ovr - k), 8'h01);
		rd_chk(`DACR_ADR_XFER, 8'h00);
		wr(`DACR_ADR_PORT, 8'h5A);
		exp_lsb = 1'b1;
		host_u.lsb_first = 1'b1;
		rd_chk(`DACR_ADR_PORT, 8'h5A);
		wr_sh(0, 8'($urandom));
		chk_out();
		wr(`DACR_ADR_PORT, 8'h18);
		exp_lsb = 1'b0;
		host_u.lsb_first = 1'b0;
		rd_chk(`DACR_ADR_PORT, 8'h18);
		for (i = 0; i < 2; i++)
		begin
			for (int s = 0; s < 4; s++)
				wr_sh(s, 8'($urandom));
			k = n_srst;
			wr(`DACR_ADR_PORT, i == 0 ? 8'h38 : 8'h1C);
			sh = DEF;
			check("soft reset", 8'(n_srst - k), 8'h01);
			chk_out();
			rd_chk(`DACR_ADR_PORT, 8'h18);
		end
		stop_test();
	end

	// Full run is near 41k mclk; limit stays under 100k mclk
	initial
	begin
		#450us;
		num_errors++;
		stop_test();
	end
endmodule
